// [rtl/ompc_consts.svh]
/*
  Register offsets, field positions, reset values and timing counts of the
  operating mode controller. Assumes inclusion by bare name from rtl/.
*/
`ifndef OMPC_CONSTS_SVH
`define OMPC_CONSTS_SVH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define OMPC_OSC_MODE_OFFS   4'h0
`define OMPC_P1_WAKE_OFFS    4'h4
`define OMPC_STATUS_OFFS     4'h8

// ----------------------------------------------------------------------
// Field positions of the oscillator mode register and width of the port 1 wake field
// ----------------------------------------------------------------------
`define OMPC_STOP_BIT        1
`define OMPC_SLOW_BIT        2
`define OMPC_SLEEP_BIT       3
`define OMPC_IDLE_BIT        4
`define OMPC_P1_WIDTH        7

// ----------------------------------------------------------------------
// Reset values, timing counts and bus response codes
// ----------------------------------------------------------------------
`define OMPC_OSC_MODE_RST    32'h0000_0000
`define OMPC_P1_WAKE_RST     7'h00
`define OMPC_WARMUP_TICKS    6'h20
`define OMPC_SLOW_DIV        2'h3
`define OMPC_RESP_OK         2'h0
`define OMPC_RESP_ERR        2'h2

`endif

// [rtl/ompc_pkg.sv]
/*
  Types of the operating mode controller. Assumes nothing beyond itself.
*/
package ompc_pkg;

  // Controller state; codes are reported in the status register.
  typedef enum logic [2:0] {
    OMPC_NORMAL = 3'b000,
    OMPC_SLOW   = 3'b001,
    OMPC_SLEEP  = 3'b010,
    OMPC_GREEN  = 3'b011,
    OMPC_WARMUP = 3'b100,
    OMPC_NOCLK  = 3'b101
  } ompc_state_type;

endpackage

// [rtl/ompc_wake_detect.sv]
/*
  Level change detector for the wake pins. Assumes the pins are synchronous
  to clock and that arm pulses once as a halted state is entered.
*/
`timescale 1ns/1ps
`default_nettype none

module ompc_wake_detect (
  input  wire logic        clock, // System clock.
  input  wire logic        rst,   // Synchronous reset, active high.
  input  wire logic        arm,   // Capture pins as the reference.
  input  wire logic [14:0] pins,  // Port 1 over port 0 pin levels.
  input  wire logic [14:0] mask,  // Pins allowed to wake.
  output logic             wake   // Registered change seen.
);

  logic [14:0] sample;
  logic [14:0] snap;

  // ----------------------------------------------------------------------
  // Sample and reference
  // ----------------------------------------------------------------------
  // Pins are registered once; the reference is taken on arm.
  always_ff @(posedge clock) begin
    if (rst) begin
      sample <= 15'h0000;
      snap   <= 15'h0000;
    end else begin
      sample <= pins;
      if (arm) begin
        snap <= sample;
      end
    end
  end

  // Wake is held off on the arm cycle so a stale reference cannot fire.
  always_ff @(posedge clock) begin
    if (rst) begin
      wake <= 1'b0;
    end else begin
      wake <= !arm && (|((sample ^ snap) & mask));
    end
  end

endmodule

`default_nettype wire

// [rtl/ompc_slow_div.sv]
/*
  Divides the low-speed oscillator tick by four for the slow instruction
  rate. Assumes ticks are single-cycle pulses on clock.
*/
`timescale 1ns/1ps
`default_nettype none

`include "ompc_consts.svh"

module ompc_slow_div (
  input  wire logic clock,  // System clock.
  input  wire logic rst,    // Synchronous reset, active high.
  input  wire logic run,    // Divider counts while high.
  input  wire logic tick_in, // Low oscillator tick.
  output logic      tick_out // One pulse per four input ticks.
);

  logic [1:0] count;

  // Restarting on run low keeps the first slow cycle a full period.
  always_ff @(posedge clock) begin
    if (rst || !run) begin
      count    <= 2'h0;
      tick_out <= 1'b0;
    end else begin
      tick_out <= tick_in && (count == `OMPC_SLOW_DIV);
      if (tick_in) begin
        count <= count + 2'h1;
      end
    end
  end

endmodule

`default_nettype wire

// [rtl/ompc_mode_ctrl.sv]
/*
  Operating mode controller with an AXI4-Lite register slave: normal, slow,
  power down and green modes, oscillator enables, execution halt and wake.
  Assumes one clock, a synchronous active-high reset, oscillator ticks and
  pins synchronous to clock, and an AXI4-Lite master on the same clock.
*/
// Function
// - After any reset the controller starts in normal mode.
// - Normal mode runs on the high oscillator with both oscillators on.
// - Slow select 0 keeps normal mode, 1 selects slow mode.
// - Slow instruction rate is the low oscillator divided by four.
// - Entering slow mode leaves the high oscillator to the stop bit.
// - Sleep request 1 enters power down, halting execution.
// - Power down stops every oscillator.
// - Power down wakes only on port 0 or enabled port 1 changes.
// - Power down always wakes into normal mode.
// - Wake from power down clears the sleep request bit.
// - Stop bit set in normal mode halts like power down but leaves the low oscillator on.
// - Idle request 1 enters green mode; current clock keeps running.
// - Green mode wakes on pin change or wake timer overflow.
// - Green mode wakes into slow mode if slow select is 1, else into normal mode.
// - Wake from green mode clears the idle request bit.
// - In green mode the wake timer and the PWM keep counting.
// - PWM runs in green mode; its overflow never wakes.
// - In green mode other oscillators follow the mode configuration.
// - Stop bit 0 runs the high oscillator, 1 stops it.
// - Mode field: 00 normal, 01 sleep, 10 green, 11 reserved.
// - Power down wake waits 32 high oscillator clocks before normal.
`timescale 1ns/1ps
`default_nettype none

`include "ompc_consts.svh"

module ompc_mode_ctrl
  import ompc_pkg::*;
(
  input  wire logic        clock,          // System clock, 125 MHz.
  input  wire logic        rst,            // Synchronous reset, active high.
  input  wire logic [3:0]  s_axi_awaddr,   // Write address.
  input  wire logic        s_axi_awvalid,  // Write address valid.
  output logic             s_axi_awready,  // Write address ready.
  input  wire logic [31:0] s_axi_wdata,    // Write data.
  input  wire logic [3:0]  s_axi_wstrb,    // Write byte strobes.
  input  wire logic        s_axi_wvalid,   // Write data valid.
  output logic             s_axi_wready,   // Write data ready.
  output logic [1:0]       s_axi_bresp,    // Write response.
  output logic             s_axi_bvalid,   // Write response valid.
  input  wire logic        s_axi_bready,   // Write response ready.
  input  wire logic [3:0]  s_axi_araddr,   // Read address.
  input  wire logic        s_axi_arvalid,  // Read address valid.
  output logic             s_axi_arready,  // Read address ready.
  output logic [31:0]      s_axi_rdata,    // Read data.
  output logic [1:0]       s_axi_rresp,    // Read response.
  output logic             s_axi_rvalid,   // Read data valid.
  input  wire logic        s_axi_rready,   // Read data ready.
  input  wire logic        high_osc_tick,  // High oscillator clock pulse.
  input  wire logic        low_osc_tick,   // Low RC oscillator clock pulse.
  input  wire logic [7:0]  port0_pins,     // Port 0 pin levels.
  input  wire logic [6:0]  port1_pins,     // Port 1 pin levels.
  input  wire logic        wake_timer_ovf, // Wake-capable timer overflow.
  input  wire logic        pwm_timer_ovf,  // PWM timer overflow, never wakes.
  output logic             high_osc_en,    // High oscillator enable.
  output logic             low_osc_en,     // Low RC oscillator enable.
  output logic             sys_clk_low,    // System clock is the low clock.
  output logic             cpu_run,        // Instruction execution allowed.
  output logic             instr_tick,     // Instruction rate pulse.
  output logic             wake_timer_run, // Wake timer may count.
  output logic             pwm_run,        // PWM and buzzer may run.
  output logic [2:0]       mode_state      // Current controller state.
);

  ompc_state_type state;
  ompc_state_type next_state;
  logic           high_osc_stop;
  logic           slow_clock_select;
  logic [1:0]     cpu_mode_field;
  logic [6:0]     port1_wake_enable;
  logic [5:0]     warm_count;
  logic           pin_wake;
  logic           arm;
  logic           slow_tick;
  logic           wr_go;
  logic           rd_go;
  logic           sleep_request;
  logic           idle_request;
  logic           warm_done;

  assign sleep_request = cpu_mode_field == 2'b01;
  assign idle_request  = cpu_mode_field == 2'b10;
  assign wr_go = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  assign rd_go = s_axi_arvalid && s_axi_arready;
  assign warm_done = high_osc_tick && (warm_count == `OMPC_WARMUP_TICKS - 6'h01);
  // Halted states are entered from a running state; arm the pin reference.
  assign arm = (next_state != state) &&
               (next_state == OMPC_SLEEP || next_state == OMPC_NOCLK ||
                next_state == OMPC_GREEN);

  // ----------------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------------
  function automatic logic [31:0] read_word(input logic [3:0] addr);
    case (addr)
      `OMPC_OSC_MODE_OFFS: read_word = {27'h0, cpu_mode_field,
                                        slow_clock_select, high_osc_stop, 1'b0};
      `OMPC_P1_WAKE_OFFS:  read_word = {25'h0, port1_wake_enable};
      `OMPC_STATUS_OFFS:   read_word = {26'h0, cpu_run, low_osc_en, high_osc_en, mode_state};
      default:             read_word = 32'h0000_0000;
    endcase
  endfunction

  function automatic logic mapped(input logic [3:0] addr);
    mapped = (addr == `OMPC_OSC_MODE_OFFS) || (addr == `OMPC_P1_WAKE_OFFS) ||
             (addr == `OMPC_STATUS_OFFS);
  endfunction

  // ----------------------------------------------------------------------
  // AXI4-Lite write channel
  // ----------------------------------------------------------------------
  // Address and data are taken together in one cycle, then answered.
  always_ff @(posedge clock) begin
    if (rst) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `OMPC_RESP_OK;
    end else begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= mapped(s_axi_awaddr) ? `OMPC_RESP_OK : `OMPC_RESP_ERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end else if (!s_axi_bvalid && !s_axi_awready &&
                   s_axi_awvalid && s_axi_wvalid) begin
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------------
  // AXI4-Lite read channel
  // ----------------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (rst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `OMPC_RESP_OK;
    end else begin
      s_axi_arready <= 1'b0;
      if (rd_go) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= read_word(s_axi_araddr);
        s_axi_rresp  <= mapped(s_axi_araddr) ? `OMPC_RESP_OK : `OMPC_RESP_ERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end else if (!s_axi_rvalid && !s_axi_arready && s_axi_arvalid) begin
        s_axi_arready <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Oscillator mode register
  // ----------------------------------------------------------------------
  // Hardware clears on wake; a software write in the same cycle wins, since
  // it can only come from a master that saw the wake already.
  always_ff @(posedge clock) begin
    if (rst) begin
      high_osc_stop     <= 1'(`OMPC_OSC_MODE_RST >> `OMPC_STOP_BIT);
      slow_clock_select <= 1'(`OMPC_OSC_MODE_RST >> `OMPC_SLOW_BIT);
      cpu_mode_field    <= 2'b00;
    end else if (wr_go && s_axi_awaddr == `OMPC_OSC_MODE_OFFS && s_axi_wstrb[0]) begin
      high_osc_stop     <= s_axi_wdata[`OMPC_STOP_BIT];
      slow_clock_select <= s_axi_wdata[`OMPC_SLOW_BIT];
      // The reserved code is dropped so it never halts the system.
      cpu_mode_field    <= (&s_axi_wdata[`OMPC_IDLE_BIT:`OMPC_SLEEP_BIT]) ? 2'b00 :
                           s_axi_wdata[`OMPC_IDLE_BIT:`OMPC_SLEEP_BIT];
    end else if ((state == OMPC_SLEEP || state == OMPC_NOCLK) && pin_wake) begin
      cpu_mode_field    <= 2'b00;
      slow_clock_select <= 1'b0;
      high_osc_stop     <= 1'b0;
    end else if (state == OMPC_GREEN && (pin_wake || wake_timer_ovf)) begin
      cpu_mode_field    <= 2'b00;
    end
  end

  // Port 1 wake enables.
  always_ff @(posedge clock) begin
    if (rst) begin
      port1_wake_enable <= `OMPC_P1_WAKE_RST;
    end else if (wr_go && s_axi_awaddr == `OMPC_P1_WAKE_OFFS && s_axi_wstrb[0]) begin
      port1_wake_enable <= s_axi_wdata[`OMPC_P1_WIDTH-1:0];
    end
  end

  // ----------------------------------------------------------------------
  // Mode state machine
  // ----------------------------------------------------------------------
  always_comb begin
    next_state = state;
    case (state)
      OMPC_NORMAL: begin
        if (sleep_request) begin
          next_state = OMPC_SLEEP;
        end else if (idle_request) begin
          next_state = OMPC_GREEN;
        end else if (slow_clock_select) begin
          next_state = OMPC_SLOW;
        end else if (high_osc_stop) begin
          next_state = OMPC_NOCLK;
        end
      end
      OMPC_SLOW: begin
        if (sleep_request) begin
          next_state = OMPC_SLEEP;
        end else if (idle_request) begin
          next_state = OMPC_GREEN;
        end else if (!slow_clock_select) begin
          // Software is expected to have warmed the high clock already.
          next_state = high_osc_stop ? OMPC_NOCLK : OMPC_NORMAL;
        end
      end
      OMPC_SLEEP, OMPC_NOCLK: begin
        if (pin_wake) begin
          next_state = OMPC_WARMUP;
        end
      end
      OMPC_GREEN: begin
        // The PWM overflow is left out of this decision on purpose.
        if (pin_wake || wake_timer_ovf) begin
          next_state = slow_clock_select ? OMPC_SLOW : OMPC_NORMAL;
        end
      end
      OMPC_WARMUP: begin
        if (warm_done) begin
          next_state = OMPC_NORMAL;
        end
      end
      default: begin
        next_state = OMPC_NORMAL;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      state <= OMPC_NORMAL;
    end else begin
      state <= next_state;
    end
  end

  // Counts high oscillator clocks after a power down wake.
  always_ff @(posedge clock) begin
    if (rst || state != OMPC_WARMUP) begin
      warm_count <= 6'h00;
    end else if (high_osc_tick) begin
      warm_count <= warm_count + 6'h01;
    end
  end

  // ----------------------------------------------------------------------
  // Wake detection and slow rate
  // ----------------------------------------------------------------------
  ompc_wake_detect u_wake (
    .clock (clock),
    .rst   (rst),
    .arm   (arm),
    .pins  ({port1_pins, port0_pins}),
    .mask  ({port1_wake_enable, 8'hFF}),
    .wake  (pin_wake)
  );

  ompc_slow_div u_div (
    .clock    (clock),
    .rst      (rst),
    .run      (state == OMPC_SLOW),
    .tick_in  (low_osc_tick),
    .tick_out (slow_tick)
  );

  // ----------------------------------------------------------------------
  // Oscillator and execution outputs
  // ----------------------------------------------------------------------
  // Outputs follow the state one cycle later; all come from flip-flops.
  always_ff @(posedge clock) begin
    if (rst) begin
      high_osc_en    <= 1'b1;
      low_osc_en     <= 1'b1;
      sys_clk_low    <= 1'b0;
      cpu_run        <= 1'b0;
      wake_timer_run <= 1'b0;
      pwm_run        <= 1'b0;
      mode_state     <= OMPC_NORMAL;
    end else begin
      // High clock: on in normal and warm-up, off in power down and no-clock, else the stop bit decides.
      high_osc_en    <= (state == OMPC_NORMAL) || (state == OMPC_WARMUP) ||
                        ((state == OMPC_SLOW || state == OMPC_GREEN) &&
                         !high_osc_stop);
      low_osc_en     <= (state != OMPC_SLEEP);
      sys_clk_low    <= (state == OMPC_SLOW) ||
                        (state == OMPC_GREEN && slow_clock_select);
      cpu_run        <= (state == OMPC_NORMAL) || (state == OMPC_SLOW);
      wake_timer_run <= (state == OMPC_NORMAL) || (state == OMPC_SLOW) ||
                        (state == OMPC_GREEN);
      pwm_run        <= (state == OMPC_NORMAL) || (state == OMPC_SLOW) ||
                        (state == OMPC_GREEN);
      mode_state     <= state;
    end
  end

  // Instruction rate: high clock in normal, a quarter of the low clock in slow.
  always_ff @(posedge clock) begin
    if (rst) begin
      instr_tick <= 1'b0;
    end else begin
      instr_tick <= (state == OMPC_NORMAL && high_osc_tick) ||
                    (state == OMPC_SLOW && slow_tick);
    end
  end

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  reset_normal_a: assert property (@(posedge clock)
    $past(rst) |-> state == OMPC_NORMAL)
    else $error("State not normal after reset.");
  sleep_entry_a: assert property (@(posedge clock) disable iff (rst)
    (state == OMPC_NORMAL && sleep_request) |=> state == OMPC_SLEEP ##1 !cpu_run)
    else $error("Sleep request did not halt execution.");
  sleep_osc_a: assert property (@(posedge clock) disable iff (rst)
    $past(state) == OMPC_SLEEP && state == OMPC_SLEEP |-> !high_osc_en && !low_osc_en)
    else $error("Oscillator running in power down.");
  sleep_wake_a: assert property (@(posedge clock) disable iff (rst)
    (state == OMPC_SLEEP && !pin_wake) |=> state == OMPC_SLEEP)
    else $error("Power down left without a pin change.");
  wake_clear_a: assert property (@(posedge clock) disable iff (rst)
    (state == OMPC_SLEEP && pin_wake && !wr_go) |=>
      cpu_mode_field == 2'b00 && !slow_clock_select && state == OMPC_WARMUP)
    else $error("Sleep wake did not clear the request.");
  warmup_len_a: assert property (@(posedge clock) disable iff (rst)
    (state == OMPC_WARMUP && warm_count == 6'h00 && high_osc_tick) |=>
      state == OMPC_WARMUP)
    else $error("Warm-up ended early.");
  green_return_a: assert property (@(posedge clock) disable iff (rst)
    (state == OMPC_GREEN && wake_timer_ovf && slow_clock_select && !wr_go) |=>
      state == OMPC_SLOW && cpu_mode_field == 2'b00)
    else $error("Green wake did not return to slow mode.");
  pwm_nowake_a: assert property (@(posedge clock) disable iff (rst)
    (state == OMPC_GREEN && pwm_timer_ovf && !wake_timer_ovf && !pin_wake) |=>
      state == OMPC_GREEN ##1 pwm_run && !cpu_run)
    else $error("PWM overflow woke the system.");
  noclk_entry_a: assert property (@(posedge clock) disable iff (rst)
    (state == OMPC_NORMAL && high_osc_stop && !slow_clock_select &&
     cpu_mode_field == 2'b00) |=> state == OMPC_NOCLK ##1 !cpu_run)
    else $error("Stop bit in normal mode did not halt.");
  slow_rate_a: assert property (@(posedge clock) disable iff (rst)
    (state == OMPC_SLOW && slow_tick) |=> instr_tick)
    else $error("Slow tick not passed to instruction rate.");

endmodule
`default_nettype wire

// [verif/tb_top.sv]
/*
  Self-checking bench for the operating mode controller: reset state, slow
  mode, green mode, power down and no-clock halt, wake and warm-up.
  Assumes the design files under rtl/ and the constants header on the path.
*/
`timescale 1ns/1ps
`default_nettype none

`include "ompc_consts.svh"

`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin err_count++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end

module tb_top;
  import ompc_pkg::*;
  // ----------------------------------------------------------------------
  // Stimulus and observed signals
  // ----------------------------------------------------------------------
  logic        clock = 0, rst = 1;
  logic [3:0]  s_axi_awaddr = 0, s_axi_araddr = 0, s_axi_wstrb = 4'hF;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata;
  logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic        s_axi_arvalid = 0, s_axi_rready = 0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        high_osc_tick = 0, low_osc_tick = 0, wake_timer_ovf = 0, pwm_timer_ovf = 0;
  logic [7:0]  port0_pins = 0;
  logic [6:0]  port1_pins = 0;
  logic        high_osc_en, low_osc_en, sys_clk_low, cpu_run, instr_tick;
  logic        wake_timer_run, pwm_run;
  logic [2:0]  mode_state;
  int          err_count = 0, total_checks = 0, cyc = 0, itc = 0;

  ompc_mode_ctrl i_dut (.clock, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .high_osc_tick, .low_osc_tick,
    .port0_pins, .port1_pins, .wake_timer_ovf, .pwm_timer_ovf, .high_osc_en, .low_osc_en,
    .sys_clk_low, .cpu_run, .instr_tick, .wake_timer_run, .pwm_run, .mode_state);

  // Free-running clock and a watchdog so a lost handshake cannot hang the run.
  always #4 clock = ~clock;
  always @(posedge clock) begin
    cyc++;
    if (instr_tick === 1'b1) itc++;
    if (cyc == 6000) begin
      err_count++;
      results();
    end
  end

  // ----------------------------------------------------------------------
  // Bus and helper tasks
  // ----------------------------------------------------------------------
  task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] r);
    @(posedge clock);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do @(posedge clock); while (s_axi_awready !== 1'b1);
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid <= 1'b0;
    while (s_axi_bvalid !== 1'b1) @(posedge clock);
    `CHK(s_axi_bresp, r)
    s_axi_bready <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, input logic [31:0] e, input logic [1:0] r);
    @(posedge clock);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge clock); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    while (s_axi_rvalid !== 1'b1) @(posedge clock);
    `CHK(s_axi_rdata, e)
    `CHK(s_axi_rresp, r)
    s_axi_rready <= 1'b0;
  endtask

  // Oscillator pulses are spaced two cycles apart, as a slow clock would be.
  task automatic ticks(input int n, input logic [1:0] sel);
    repeat (n) begin
      @(posedge clock);
      {low_osc_tick, high_osc_tick} <= sel;
      @(posedge clock);
      {low_osc_tick, high_osc_tick} <= 2'b00;
    end
    repeat (3) @(posedge clock);
  endtask

  task automatic halt(input logic [31:0] d, input logic [2:0] st, input bit p1);
    wr(`OMPC_OSC_MODE_OFFS, d, `OMPC_RESP_OK);
    repeat (4) @(posedge clock);
    `CHK({mode_state, cpu_run, high_osc_en, low_osc_en}, {st, 2'b00, st == OMPC_NOCLK})
    `CHK({wake_timer_run, pwm_run}, 2'b00)
    wake_timer_ovf <= 1'b1;
    port1_pins[2] <= ~port1_pins[2];
    @(posedge clock);
    wake_timer_ovf <= 1'b0;
    repeat (6) @(posedge clock);
    `CHK(mode_state, st)
    if (p1) port1_pins[0] <= ~port1_pins[0];
    else port0_pins[7] <= ~port0_pins[7];
    repeat (6) @(posedge clock);
    `CHK(mode_state, OMPC_WARMUP)
    ticks(31, 2'b01);
    `CHK(mode_state, OMPC_WARMUP)
    ticks(1, 2'b01);
    `CHK({mode_state, cpu_run, sys_clk_low}, {OMPC_NORMAL, 2'b10})
    rd(`OMPC_OSC_MODE_OFFS, 32'h0000_0000, `OMPC_RESP_OK);
    $display("halt test done");
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  // Green waits on a timer pulse, so its cases are ordered from slow back to normal.
  initial begin
    repeat (5) @(posedge clock);
    rst <= 1'b0;
    repeat (2) @(posedge clock);
    reset_test();
    slow_test();
    green_test();
    wr(`OMPC_P1_WAKE_OFFS, 32'h0000_0001, `OMPC_RESP_OK);
    wr(`OMPC_OSC_MODE_OFFS, 32'h0000_0004, `OMPC_RESP_OK);
    halt(32'h0000_000C, OMPC_SLEEP, 1'b0);
    halt(32'h0000_0002, OMPC_NOCLK, 1'b0);
    halt(32'h0000_0008, OMPC_SLEEP, 1'b1);
    results();
  end

  // Reset state, normal-mode instruction rate and bus error responses.
  task automatic reset_test();
    `CHK({mode_state, cpu_run, high_osc_en, low_osc_en, sys_clk_low}, 7'h0E)
    itc = 0;
    ticks(5, 2'b01);
    `CHK(itc, 5)
    rd(`OMPC_STATUS_OFFS, 32'h0000_0038, `OMPC_RESP_OK);
    wr(4'hC, 32'h0000_0001, `OMPC_RESP_ERR);
    rd(4'hC, 32'h0000_0000, `OMPC_RESP_ERR);
    wr(`OMPC_OSC_MODE_OFFS, 32'h0000_0018, `OMPC_RESP_OK);
    rd(`OMPC_OSC_MODE_OFFS, 32'h0000_0000, `OMPC_RESP_OK);
    $display("reset test done");
  endtask

  // Slow entry, quarter-rate instruction pulses and stopping the high clock.
  task automatic slow_test();
    wr(`OMPC_OSC_MODE_OFFS, 32'h0000_0004, `OMPC_RESP_OK);
    repeat (4) @(posedge clock);
    `CHK({mode_state, sys_clk_low, high_osc_en, low_osc_en}, {OMPC_SLOW, 3'b111})
    itc = 0;
    ticks(16, 2'b10);
    `CHK(itc, 4)
    wr(`OMPC_OSC_MODE_OFFS, 32'h0000_0006, `OMPC_RESP_OK);
    repeat (4) @(posedge clock);
    `CHK({cpu_run, high_osc_en, low_osc_en}, 3'b101)
    $display("slow test done");
  endtask

  // Green mode entered from slow and from normal, timer and pin wake.
  task automatic green_test();
    wr(`OMPC_OSC_MODE_OFFS, 32'h0000_0016, `OMPC_RESP_OK);
    pwm_timer_ovf <= 1'b1;
    @(posedge clock);
    pwm_timer_ovf <= 1'b0;
    repeat (4) @(posedge clock);
    `CHK({mode_state, cpu_run, high_osc_en, wake_timer_run, pwm_run}, {OMPC_GREEN, 4'h3})
    wake_timer_ovf <= 1'b1;
    @(posedge clock);
    wake_timer_ovf <= 1'b0;
    repeat (4) @(posedge clock);
    `CHK({mode_state, cpu_run}, {OMPC_SLOW, 1'b1})
    rd(`OMPC_OSC_MODE_OFFS, 32'h0000_0006, `OMPC_RESP_OK);
    wr(`OMPC_OSC_MODE_OFFS, 32'h0000_0004, `OMPC_RESP_OK);
    wr(`OMPC_OSC_MODE_OFFS, 32'h0000_0000, `OMPC_RESP_OK);
    wr(`OMPC_OSC_MODE_OFFS, 32'h0000_0010, `OMPC_RESP_OK);
    repeat (4) @(posedge clock);
    `CHK({mode_state, high_osc_en, sys_clk_low}, {OMPC_GREEN, 2'b10})
    port0_pins[3] <= 1'b1;
    repeat (6) @(posedge clock);
    `CHK(mode_state, OMPC_NORMAL)
    $display("green test done");
  endtask
endmodule

`default_nettype wire
